// ==== page_map_pkg.sv ====
// package for the page map access control block
// assumes one processor clock shared by the core and the register bus
// Overview of operation
// [R1] eight base/descriptor pairs per register set
// [R2] status word bits 15:14 pick mode sets
// [R3] virtual address 15:13 index the pair
// [R4] status reg3 bits 2:0 enable data space
// [R5] no data space: instruction set maps everything
// [R6] fetch, index words: instruction; pointers, operands: data
// [R7] general registers make no memory reference
// [R8] base register holds 16-bit block number
// [R9] abort suppresses reference; trap lets it complete
// [R10] trap signalled only after instruction ends
// [R11] any modifying reference counts as write
// [R12] codes 000, 011, 111 abort all
// [R13] read-only codes abort writes; 001 traps reads
// [R14] code 100 traps all; 101 plain
// [R15] descriptor bit 3 gives expansion direction
// [R16] write reference sets modified bit 6
// [R17] software write to pair clears modified
// [R18] trap conditions set attention bit 7
// [R19] write under code 101 sets attention
// [R20] software write to pair clears attention
// [R21] code 110 aborts all accesses
package page_map_pkg;
  // =====================================================
  // register map, byte addresses
  localparam logic [11:0] PAIR_SPAN = 12'h180;
  localparam logic [11:0] CTRL_OFF = 12'h200;
  localparam logic [11:0] DSPACE_OFF = 12'h204;
  localparam int CTRL_XLATE_BIT = 0;
  localparam int CTRL_PEND_BIT = 1;
  localparam logic [2:0] DSPACE_RESET = 3'h0;
  // =====================================================
  // descriptor fields
  localparam int CODE_LSB = 0;
  localparam int EXPAND_BIT = 3;
  localparam int MOD_BIT = 6;
  localparam int ATTN_BIT = 7;
  localparam logic [15:0] DESC_RESET = 16'h0000;
  localparam logic [15:0] BASE_RESET = 16'h0000;
  localparam logic [15:0] DESC_SW_MASK = 16'hff3f;
  // =====================================================
  // access codes
  localparam logic [2:0] CODE_NONRES = 3'h0;
  localparam logic [2:0] CODE_RO_TRAP = 3'h1;
  localparam logic [2:0] CODE_RO = 3'h2;
  localparam logic [2:0] CODE_RSV3 = 3'h3;
  localparam logic [2:0] CODE_RW_TRAP = 3'h4;
  localparam logic [2:0] CODE_RW = 3'h5;
  localparam logic [2:0] CODE_RSV6 = 3'h6;
  localparam logic [2:0] CODE_RSV7 = 3'h7;
  // =====================================================
  // execution modes in processor status word bits 15:14
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REF_FETCH = 3'h0,
    REF_INDEX = 3'h1,
    REF_INDIRECT = 3'h2,
    REF_OPERAND = 3'h3,
    REF_REGISTER = 3'h4
  } ref_class_e;

  typedef struct packed {
    logic valid;
    logic [15:0] va;
    ref_class_e cls;
    logic write;
    logic [1:0] exec_mode;
  } ref_req_s;

  typedef struct packed {
    logic valid;
    logic abort;
    logic trap;
    logic dspace;
    logic expand_down;
    logic [2:0] page;
    logic [15:0] base;
  } ref_resp_s;
endpackage : page_map_pkg

// ==== page_map_access_control.sv ====
// page register sets, access checks and page statistics
// assumes the core on aclk, one reference per cycle, axi4-lite master
`timescale 1ns/1ps
`default_nettype none
module page_map_access_control
  import page_map_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ref_req_s ref_req,
  input wire logic instr_done,
  output ref_resp_s ref_resp,
  output logic mmu_trap
);
  localparam int ENTRIES = 48;

  if (ADDR_W < 12) begin : g_chk
    $error("address width too small for the register map");
  end

  typedef struct packed {
    logic [ENTRIES-1:0][15:0] base;
    logic [ENTRIES-1:0][15:0] desc;
    logic xlate_en;
    logic [2:0] dspace_en;
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    ref_resp_s resp;
    logic trap_pending;
    logic mmu_trap;
  } state_s;

  state_s s_q, s_d;

  // =====================================================
  // helper functions
  function automatic logic [1:0] mode_index(input logic [1:0] sw);
    case (sw)
      MODE_KERNEL: mode_index = 2'h0;
      MODE_SUPER: mode_index = 2'h1;
      MODE_USER: mode_index = 2'h2;
      default: mode_index = 2'h3;
    endcase
  endfunction : mode_index

  function automatic logic [5:0] entry_of(input logic [1:0] mi,
                                          input logic ds,
                                          input logic [2:0] page);
    // invalid mode kept inside the array; the reference aborts anyway
    entry_of = (mi == 2'h3) ? 6'h0 : {mi, ds, page};
  endfunction : entry_of

  // returns {abort, trap}
  function automatic logic [1:0] check_access(input logic [2:0] code,
                                              input logic wr);
    case (code)
      CODE_RO_TRAP: check_access = wr ? 2'b10 : 2'b01; // [R13]
      CODE_RO: check_access = wr ? 2'b10 : 2'b00; // [R13]
      CODE_RW_TRAP: check_access = 2'b01; // [R14]
      CODE_RW: check_access = 2'b00; // [R14]
      // nonresident, reserved and undefined codes
      default: check_access = 2'b10; // [R12] [R21]
    endcase
  endfunction : check_access

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    lane_merge = old;
    if (strb[0]) lane_merge[7:0] = data[7:0];
    if (strb[1]) lane_merge[15:8] = data[15:8];
  endfunction : lane_merge

  // =====================================================
  // reference lookup
  logic [1:0] ref_mi;
  logic ref_mem;
  logic ref_dspace;
  logic [5:0] ref_idx;
  logic [15:0] ref_desc;
  logic [2:0] ref_code;
  logic ref_abort;
  logic ref_trap;
  logic ref_checked;

  always_comb begin
    ref_mi = mode_index(ref_req.exec_mode); // [R2]
    ref_mem = ref_req.valid && (ref_req.cls != REF_REGISTER); // [R7]
    // data space only for pointers and operands, when enabled
    ref_dspace = (ref_mi != 2'h3) && s_q.dspace_en[ref_mi] &&
                 (ref_req.cls == REF_INDIRECT ||
                  ref_req.cls == REF_OPERAND); // [R4] [R5] [R6]
    ref_idx = entry_of(ref_mi, ref_dspace, ref_req.va[15:13]); // [R3]
    ref_desc = s_q.desc[ref_idx]; // [R1]
    ref_code = ref_desc[CODE_LSB +: 3];
    ref_checked = ref_mem && s_q.xlate_en;
    {ref_abort, ref_trap} = check_access(ref_code, ref_req.write); // [R11]
    if (ref_mi == 2'h3) begin
      ref_abort = 1'b1;
      ref_trap = 1'b0;
    end
  end

  // =====================================================
  // bus decode
  logic wr_fire;
  logic [11:0] wa;
  logic [11:0] ra;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;

  always_comb begin
    wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    wa = {s_q.awaddr[11:2], 2'b00};
    ra = {s_axi_araddr[11:2], 2'b00};
    wr_idx = wa[8:3];
    rd_idx = ra[8:3];
  end

  // =====================================================
  // next state
  always_comb begin
    s_d = s_q;
    // write address and data taken in either order
    if (s_axi_awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = 12'(s_axi_awaddr);
    end
    if (s_axi_wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) s_d.bvalid = 1'b0;
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      if (wa < PAIR_SPAN) begin
        // statistics bits cleared on either register of the pair
        if (wa[2]) begin // [R17] [R20]
          s_d.desc[wr_idx] = lane_merge(s_q.desc[wr_idx], s_q.wdata,
                                        s_q.wstrb) & DESC_SW_MASK;
        end else begin
          s_d.base[wr_idx] = lane_merge(s_q.base[wr_idx], s_q.wdata,
                                        s_q.wstrb); // [R8]
          s_d.desc[wr_idx][MOD_BIT] = 1'b0; // [R17]
          s_d.desc[wr_idx][ATTN_BIT] = 1'b0; // [R20]
        end
      end else if (wa == CTRL_OFF) begin
        if (s_q.wstrb[0]) s_d.xlate_en = s_q.wdata[CTRL_XLATE_BIT];
      end else if (wa == DSPACE_OFF) begin
        if (s_q.wstrb[0]) s_d.dspace_en = s_q.wdata[2:0]; // [R4]
      end else begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    // read channel
    if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0;
      if (ra < PAIR_SPAN) begin
        s_d.rdata[15:0] = ra[2] ? s_q.desc[rd_idx] : s_q.base[rd_idx];
      end else if (ra == CTRL_OFF) begin
        s_d.rdata[CTRL_XLATE_BIT] = s_q.xlate_en;
        s_d.rdata[CTRL_PEND_BIT] = s_q.trap_pending;
      end else if (ra == DSPACE_OFF) begin
        s_d.rdata[2:0] = s_q.dspace_en;
      end else begin
        s_d.rresp = RESP_SLVERR;
      end
    end
    // reference answer, one cycle after the request
    s_d.resp.valid = ref_mem;
    s_d.resp.abort = ref_checked && ref_abort; // [R9]
    s_d.resp.trap = ref_checked && !ref_abort && ref_trap; // [R9]
    s_d.resp.dspace = ref_dspace;
    s_d.resp.page = ref_req.va[15:13];
    s_d.resp.base = s_q.base[ref_idx]; // [R8]
    s_d.resp.expand_down = ref_desc[EXPAND_BIT]; // [R15]
    // statistics; set wins over a clear by software
    if (ref_checked && !ref_abort) begin
      if (ref_req.write) s_d.desc[ref_idx][MOD_BIT] = 1'b1; // [R16]
      if (ref_trap || (ref_req.write && ref_code == CODE_RW)) begin
        s_d.desc[ref_idx][ATTN_BIT] = 1'b1; // [R18] [R19]
      end
    end
    // trap held back until the instruction completes
    s_d.mmu_trap = instr_done && (s_q.trap_pending ||
                   (ref_checked && !ref_abort && ref_trap)); // [R10]
    if (instr_done) begin
      s_d.trap_pending = 1'b0;
    end else if (ref_checked && !ref_abort && ref_trap) begin
      s_d.trap_pending = 1'b1; // [R10]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.dspace_en <= DSPACE_RESET;
      for (int i = 0; i < ENTRIES; i++) begin
        s_q.base[i] <= BASE_RESET;
        s_q.desc[i] <= DESC_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // =====================================================
  // outputs
  always_comb begin
    s_axi_awready = !s_q.aw_held;
    s_axi_wready = !s_q.w_held;
    s_axi_bvalid = s_q.bvalid;
    s_axi_bresp = s_q.bresp;
    s_axi_arready = !s_q.rvalid;
    s_axi_rvalid = s_q.rvalid;
    s_axi_rdata = s_q.rdata;
    s_axi_rresp = s_q.rresp;
    ref_resp = s_q.resp;
    mmu_trap = s_q.mmu_trap;
  end

  // =====================================================
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_abort_unused;
    ref_checked && (ref_code == CODE_NONRES || ref_code == CODE_RSV3 ||
      ref_code == CODE_RSV7 || ref_code == CODE_RSV6)
      |=> ref_resp.valid && ref_resp.abort && !ref_resp.trap;
  endproperty
  a_abort_unused: assert property (p_abort_unused) // [R12]
    else $error("unused access code not aborted");

  property p_ro_read;
    ref_checked && ref_code == CODE_RO && !ref_req.write && ref_mi != 2'h3
      |=> !ref_resp.abort && !ref_resp.trap;
  endproperty
  a_ro_read: assert property (p_ro_read) // [R13]
    else $error("read-only read not plain");

  property p_ro_write;
    ref_checked && ref_req.write &&
      (ref_code == CODE_RO || ref_code == CODE_RO_TRAP) |=> ref_resp.abort;
  endproperty
  a_ro_write: assert property (p_ro_write) // [R13]
    else $error("write to read-only page not aborted");

  property p_ro_trap_read;
    ref_checked && ref_code == CODE_RO_TRAP && !ref_req.write &&
      ref_mi != 2'h3 |=> ref_resp.trap && !ref_resp.abort;
  endproperty
  a_ro_trap_read: assert property (p_ro_trap_read) // [R13]
    else $error("read under trapping read-only code did not trap");

  property p_rw_trap;
    ref_checked && ref_code == CODE_RW_TRAP && ref_mi != 2'h3
      |=> ref_resp.trap && !ref_resp.abort;
  endproperty
  a_rw_trap: assert property (p_rw_trap) // [R14]
    else $error("trapping read/write code did not trap");

  property p_rw_plain;
    ref_checked && ref_code == CODE_RW && ref_mi != 2'h3
      |=> !ref_resp.trap && !ref_resp.abort;
  endproperty
  a_rw_plain: assert property (p_rw_plain) // [R14]
    else $error("plain read/write code trapped or aborted");

  property p_xlate_off;
    ref_mem && !s_q.xlate_en |=> !ref_resp.abort && !ref_resp.trap;
  endproperty
  a_xlate_off: assert property (p_xlate_off) // [R9]
    else $error("reference checked while translation off");

  property p_bad_mode;
    ref_checked && ref_mi == 2'h3 |=> ref_resp.abort;
  endproperty
  a_bad_mode: assert property (p_bad_mode) // [R2]
    else $error("reference in invalid mode not aborted");

  property p_reg_no_ref;
    ref_req.valid && ref_req.cls == REF_REGISTER |=> !ref_resp.valid;
  endproperty
  a_reg_no_ref: assert property (p_reg_no_ref) // [R7]
    else $error("register operand made a memory reference");

  property p_trap_at_end;
    mmu_trap |-> $past(instr_done);
  endproperty
  a_trap_at_end: assert property (p_trap_at_end) // [R10]
    else $error("trap signalled outside instruction end");

  property p_pending_flush;
    s_q.trap_pending && instr_done |=> mmu_trap ##1 !mmu_trap;
  endproperty
  a_pending_flush: assert property (p_pending_flush) // [R10]
    else $error("held trap not signalled once");

  property p_mod_set;
    ref_checked && !ref_abort && ref_req.write
      |=> s_q.desc[$past(ref_idx)][MOD_BIT];
  endproperty
  a_mod_set: assert property (p_mod_set) // [R16]
    else $error("modified bit not set by write");

  property p_attn_set;
    ref_checked && !ref_abort && ref_trap
      |=> s_q.desc[$past(ref_idx)][ATTN_BIT];
  endproperty
  a_attn_set: assert property (p_attn_set) // [R18]
    else $error("attention bit not set by trap condition");

  property p_attn_write;
    ref_checked && ref_req.write && ref_code == CODE_RW && ref_mi != 2'h3
      |=> s_q.desc[$past(ref_idx)][ATTN_BIT];
  endproperty
  a_attn_write: assert property (p_attn_write) // [R19]
    else $error("attention bit not set by plain write");

  property p_mod_clear;
    wr_fire && wa < PAIR_SPAN && !ref_req.valid
      |=> !s_q.desc[$past(wr_idx)][MOD_BIT] &&
          !s_q.desc[$past(wr_idx)][ATTN_BIT];
  endproperty
  a_mod_clear: assert property (p_mod_clear) // [R17]
    else $error("statistics bits not cleared by software write");

  property p_ispace_only;
    ref_req.valid && ref_mi != 2'h3 && !s_q.dspace_en[ref_mi]
      |=> !ref_resp.dspace;
  endproperty
  a_ispace_only: assert property (p_ispace_only) // [R5]
    else $error("data space used while disabled");

  property p_page_index;
    ref_mem |=> ref_resp.page == $past(ref_req.va[15:13]);
  endproperty
  a_page_index: assert property (p_page_index) // [R3]
    else $error("page index not from address top bits");
endmodule : page_map_access_control
`default_nettype wire

// ==== core_model.sv ====
// processor core model issuing references to the page map block
// assumes one shared aclk; one reference or instruction end per call
`timescale 1ns/1ps
`default_nettype none
module core_model
  import page_map_pkg::*;
(
  input wire logic aclk,
  input wire ref_resp_s ref_resp,
  output var ref_req_s ref_req,
  output logic instr_done
);
  // =====================================================
  // idle state
  initial begin
    ref_req = '0;
    instr_done = 1'b0;
  end

  // =====================================================
  // one reference, answer one cycle after it is taken
  task automatic issue(input logic [1:0] md, input ref_class_e cl,
                       input logic [15:0] va, input logic wr,
                       output ref_resp_s r);
    @(posedge aclk);
    ref_req <= '{valid: 1'b1, va: va, cls: cl, write: wr,
                 exec_mode: md};
    @(posedge aclk);
    // released va and write fields show inverted values, not the old ones
    ref_req.valid <= 1'b0;
    ref_req.va <= ~va;
    ref_req.write <= ~wr;
    #1;
    r = ref_resp;
  endtask : issue

  task automatic finish_instr();
    @(posedge aclk);
    instr_done <= 1'b1;
    @(posedge aclk);
    instr_done <= 1'b0;
    #1;
  endtask : finish_instr
endmodule : core_model
`default_nettype wire

// ==== page_map_access_control_tb.sv ====
// testbench for the page map access control block
// assumes core_model as the core and an axi4-lite master in tasks
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module page_map_access_control_tb;
  import page_map_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, instr_done, mmu_trap;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  ref_req_s ref_req;
  ref_resp_s ref_resp;
  int n_errors = 0;
  int n_checks = 0;

  always #5 aclk = ~aclk;

  page_map_access_control u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ref_req(ref_req), .instr_done(instr_done),
    .ref_resp(ref_resp), .mmu_trap(mmu_trap));

  core_model u_core (.aclk(aclk), .ref_resp(ref_resp), .ref_req(ref_req),
    .instr_done(instr_done));

  // =====================================================
  // bus helpers
  function automatic logic [11:0] pa(input logic [1:0] m, input logic s,
                                     input logic [2:0] p, input logic w);
    return {3'h0, m, s, p, w, 2'b00};
  endfunction : pa

  function automatic logic [15:0] bv(input logic [1:0] m, input logic s);
    return {6'h0, m, 3'h0, s, 4'h2};
  endfunction : bv

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axr

  // =====================================================
  // scenarios
  task automatic t_reset;
    ref_resp_s r;
    axr(pa(2'd1, 1'b1, 3'd5, 1'b1));
    `CHK("desc_rst", {16'h0, DESC_RESET}, rd)
    axr(DSPACE_OFF);
    `CHK("dsp_rst", {29'h0, DSPACE_RESET}, rd)
    axr(12'h300);
    `CHK("rd_unmapped", RESP_SLVERR, rs)
    axw(12'h300, 32'h1);
    `CHK("wr_unmapped", RESP_SLVERR, rs)
    u_core.issue(MODE_KERNEL, REF_OPERAND, 16'h2000, 1'b1, r);
    `CHK("xlate_off", 1'b0, r.abort)
    $display("test reset done");
  endtask : t_reset

  task automatic t_codes;
    ref_resp_s r;
    logic [2:0] c;
    logic ab_r, ab_w, tr_r;
    axw(CTRL_OFF, 32'h1);
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      ab_r = (c == CODE_NONRES) || (c == CODE_RSV3) || (c[2:1] == 2'b11);
      ab_w = ab_r || (c == CODE_RO_TRAP) || (c == CODE_RO);
      tr_r = (c == CODE_RO_TRAP) || (c == CODE_RW_TRAP);
      axw(pa(2'd0, 1'b0, c, 1'b1), {28'h0, c[0], c});
      axw(pa(2'd0, 1'b0, c, 1'b0), {16'h0, 13'h120, c});
      u_core.issue(MODE_KERNEL, REF_FETCH, {c, 13'h40}, 1'b0, r);
      `CHK("rd_abort", ab_r, r.abort)
      `CHK("rd_trap", tr_r, r.trap)
      `CHK("page", c, r.page)
      `CHK("base", {13'h120, c}, r.base)
      `CHK("ed", c[0], r.expand_down)
      u_core.issue(MODE_KERNEL, REF_OPERAND, {c, 13'h80}, 1'b1, r);
      `CHK("wr_abort", ab_w, r.abort)
      `CHK("wr_trap", c == CODE_RW_TRAP, r.trap)
      axr(pa(2'd0, 1'b0, c, 1'b1));
      `CHK("modified", !ab_w, rd[MOD_BIT])
      `CHK("attention", tr_r || c == CODE_RW, rd[ATTN_BIT])
      axw(pa(2'd0, 1'b0, c, 1'b0), {16'h0, 13'h120, c});
      axr(pa(2'd0, 1'b0, c, 1'b1));
      `CHK("stat_clear", {28'h0, c[0], c}, rd)
    end
    $display("test codes done");
  endtask : t_codes

  task automatic sp_chk(input logic [1:0] md, input ref_class_e cl,
                        input logic ds, input logic [1:0] m);
    ref_resp_s r;
    u_core.issue(md, cl, 16'h4010, 1'b0, r);
    `CHK("dspace", ds, r.dspace)
    `CHK("set_base", bv(m, ds), r.base)
  endtask : sp_chk

  task automatic t_space;
    ref_resp_s r;
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 2; s++) begin
        axw(pa(2'(m), 1'(s), 3'd2, 1'b1), {29'h0, CODE_RW});
        axw(pa(2'(m), 1'(s), 3'd2, 1'b0), {16'h0, bv(2'(m), 1'(s))});
      end
    end
    axw(DSPACE_OFF, 32'h4);
    sp_chk(MODE_USER, REF_OPERAND, 1'b1, 2'd2);
    sp_chk(MODE_USER, REF_INDIRECT, 1'b1, 2'd2);
    sp_chk(MODE_USER, REF_FETCH, 1'b0, 2'd2);
    sp_chk(MODE_USER, REF_INDEX, 1'b0, 2'd2);
    sp_chk(MODE_SUPER, REF_OPERAND, 1'b0, 2'd1);
    sp_chk(MODE_KERNEL, REF_INDIRECT, 1'b0, 2'd0);
    u_core.issue(MODE_USER, REF_REGISTER, 16'h4010, 1'b1, r);
    `CHK("reg_no_ref", 1'b0, r.valid)
    u_core.issue(2'h2, REF_FETCH, 16'h4010, 1'b0, r);
    `CHK("bad_mode", 1'b1, r.abort)
    $display("test space done");
  endtask : t_space

  task automatic t_trap;
    ref_resp_s r;
    u_core.finish_instr();
    u_core.issue(MODE_KERNEL, REF_FETCH, 16'h8000, 1'b0, r);
    `CHK("trap_flag", 1'b1, r.trap)
    repeat (3) begin
      @(posedge aclk);
      #1;
      `CHK("trap_held", 1'b0, mmu_trap)
    end
    axr(CTRL_OFF);
    `CHK("pending", 32'h3, rd)
    u_core.finish_instr();
    `CHK("trap_out", 1'b1, mmu_trap)
    u_core.issue(MODE_KERNEL, REF_FETCH, 16'ha000, 1'b0, r);
    u_core.finish_instr();
    `CHK("no_trap", 1'b0, mmu_trap)
    $display("test trap done");
  endtask : t_trap

  // =====================================================
  // run control
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_codes();
    t_space();
    t_trap();
    wrap_up();
  end
endmodule : page_map_access_control_tb
`default_nettype wire
